//--- hw/dpf_pkg.sv
// Package with register map, field layouts and carriers of the pixel output formatter
package dpf_pkg;

  // ****************************************
  // Register indexes and byte addresses
  // ****************************************
  localparam logic [7:0] IDX_FMT    = 8'h18;
  localparam logic [7:0] IDX_HSW    = 8'h19;
  localparam logic [7:0] IDX_DIS    = 8'h1a;
  localparam logic [7:0] IDX_STAT   = 8'h1f;
  localparam logic [9:0] ADR_FMT    = {IDX_FMT, 2'h0};
  localparam logic [9:0] ADR_HSW    = {IDX_HSW, 2'h0};
  localparam logic [9:0] ADR_DIS    = {IDX_DIS, 2'h0};
  localparam logic [9:0] ADR_STAT   = {IDX_STAT, 2'h0};

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RST_FMT    = 8'h00;
  localparam logic [7:0] RST_HSW    = 8'h10;
  localparam logic [7:0] RST_DIS    = 8'h00;

  // ****************************************
  // Field positions of the lane disable register
  // ****************************************
  localparam int         DIS_LANES  = 6;
  localparam int         DIS_CLK_A  = 6;
  localparam int         DIS_CLK_B  = 7;

  // ****************************************
  // Buffer geometry
  // ****************************************
  localparam int         FIFO_DEPTH = 8;
  localparam int         LVL_W      = 4;

  // Output format control, bit 7 first
  typedef struct packed {
    logic line_pol;
    logic frame_pol;
    logic clk_pol;
    logic yuv422;
    logic rsvd3;
    logic swap;
    logic interleave;
    logic wide;
  } dpf_fmt_t;

  // One digitized pixel with its syncs
  typedef struct packed {
    logic       frame_sync;
    logic       line_sync;
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } dpf_pix_t;

  // One set of three byte buses
  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } dpf_bus_t;

  localparam dpf_bus_t   BUS_ZERO   = '{red: 8'h00, green: 8'h00, blue: 8'h00};

endpackage

//--- hw/dpf_formatter.sv
// Pixel output formatter with its buffer and Wishbone register slave
//
// Overview of operation
// - Narrow mode drives primaries, secondaries held low
// - Wide interleaved secondary changes on opposite edge
// - First pixel after line sync on primary, swappable
// - Narrow 4:2:2 decimates chroma, blue held low
// - Narrow mode syncs and data change on selected clock edge
// - Frame and line sync polarity selectable
// - Line sync lasts programmed pixel count
// - Disable bits three-state their byte lanes
// - Disable bits override every other setting
// - Bits 0-5 lanes, bits 6-7 data clock
`timescale 1ns/10ps
`default_nettype none

module dpf_fifo #(
  parameter int WIDTH = 26,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Fill side
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  // Drain side
  output logic                  out_valid_o,
  output logic [WIDTH-1:0]      out_data_o,
  input  wire logic             out_ready_i,
  // Fill level
  output logic [$clog2(DEPTH):0] level_o
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      cnt_r;
  logic [AW:0]      cnt_nxt;
  logic             full_r;
  wire              push = in_valid_i & ~full_r;
  wire              pop  = out_ready_i & (cnt_r != '0);

  // Handshake and read port
  assign in_ready_o  = ~full_r;
  assign out_valid_o = (cnt_r != '0);
  assign out_data_o  = mem[rd_ptr_r];
  assign level_o     = cnt_r;

  // Next fill level
  always_comb
  begin
    cnt_nxt = cnt_r;
    if (push && !pop)
      cnt_nxt = cnt_r + (AW+1)'(1);
    else if (pop && !push)
      cnt_nxt = cnt_r - (AW+1)'(1);
  end

  // Storage
  always_ff @(posedge clk_i)
  begin
    if (push)
      mem[wr_ptr_r] <= in_data_i;
  end

  // Pointers and flags
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r    <= '0;
      full_r   <= 1'b0;
    end
    else
    begin
      if (push)
        wr_ptr_r <= wr_ptr_r + AW'(1);
      if (pop)
        rd_ptr_r <= rd_ptr_r + AW'(1);
      cnt_r  <= cnt_nxt;
      full_r <= (cnt_nxt == (AW+1)'(DEPTH));
    end
  end

endmodule

module dpf_formatter (
  // Clock and reset
  input  wire logic            clk_i,
  input  wire logic            rst_i,
  // Wishbone slave
  input  wire logic            wb_cyc_i,
  input  wire logic            wb_stb_i,
  input  wire logic            wb_we_i,
  input  wire logic [9:0]      wb_adr_i,
  input  wire logic [3:0]      wb_sel_i,
  input  wire logic [31:0]     wb_dat_i,
  output logic      [31:0]     wb_dat_o,
  output logic                 wb_ack_o,
  // Pixel stream in
  input  wire logic            pix_valid_i,
  input  wire dpf_pkg::dpf_pix_t pix_data_i,
  output logic                 pix_ready_o,
  // Pixel clock from outside
  input  wire logic            pixel_clock_i,
  // Byte buses
  output logic [7:0]           red_primary_bus_o,
  output logic [7:0]           green_primary_bus_o,
  output logic [7:0]           blue_primary_bus_o,
  output logic [7:0]           red_secondary_bus_o,
  output logic [7:0]           green_secondary_bus_o,
  output logic [7:0]           blue_secondary_bus_o,
  output logic [5:0]           lane_oe_n_o,
  // Clock and syncs out
  output logic                 output_data_clock_o,
  output logic                 output_data_clock_oe_n_o,
  output logic                 line_sync_out_o,
  output logic                 frame_sync_out_o
);

  // ****************************************
  // Registers and bus slave
  // ****************************************
  dpf_pkg::dpf_fmt_t fmt_r;
  logic [7:0]        hsw_r;
  logic [7:0]        dis_r;
  logic              ack_r;
  logic [31:0]       rdat_r;
  logic [dpf_pkg::LVL_W-1:0] fifo_lvl;
  logic              phase_r;
  logic              hs_act_r;

  // Address decode
  wire        bus_req  = wb_cyc_i & wb_stb_i & ~ack_r;
  wire        wr_lane0 = bus_req & wb_we_i & wb_sel_i[0];
  wire        hit_fmt  = (wb_adr_i == dpf_pkg::ADR_FMT);
  wire        hit_hsw  = (wb_adr_i == dpf_pkg::ADR_HSW);
  wire        hit_dis  = (wb_adr_i == dpf_pkg::ADR_DIS);
  wire        hit_stat = (wb_adr_i == dpf_pkg::ADR_STAT);
  wire [7:0]  stat_val = {2'h0, fifo_lvl, phase_r, hs_act_r};

  // Read selection, unmapped reads zero
  wire [7:0]  rd_byte  = hit_fmt  ? fmt_r :
                         hit_hsw  ? hsw_r :
                         hit_dis  ? dis_r :
                         hit_stat ? stat_val : 8'h00;

  // Ack one cycle after the strobe, then drop
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_r  <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end
    else
    begin
      ack_r  <= bus_req;
      rdat_r <= {24'h00_0000, rd_byte};
    end
  end

  // Register writes on byte lane 0
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      fmt_r <= dpf_pkg::RST_FMT;
      hsw_r <= dpf_pkg::RST_HSW;
      dis_r <= dpf_pkg::RST_DIS;
    end
    else if (wr_lane0)
    begin
      if (hit_fmt)
        fmt_r <= wb_dat_i[7:0];
      if (hit_hsw)
        hsw_r <= wb_dat_i[7:0];
      if (hit_dis)
        dis_r <= wb_dat_i[7:0];
    end
  end

  // ****************************************
  // Pixel clock synchroniser and edge detect
  // ****************************************
  logic pclk_s1_r;
  logic pclk_s2_r;
  logic pclk_s3_r;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pclk_s1_r <= 1'b0;
      pclk_s2_r <= 1'b0;
      pclk_s3_r <= 1'b0;
    end
    else
    begin
      pclk_s1_r <= pixel_clock_i;
      pclk_s2_r <= pclk_s1_r;
      pclk_s3_r <= pclk_s2_r;
    end
  end

  wire tick = pclk_s2_r & ~pclk_s3_r;  // One per pixel

  // ****************************************
  // Pixel buffer
  // ****************************************
  dpf_pkg::dpf_pix_t pix;
  logic              pix_avail;
  logic              fifo_ready;

  dpf_fifo #(
    .WIDTH ($bits(dpf_pkg::dpf_pix_t)),
    .DEPTH (dpf_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (pix_valid_i),
    .in_data_i   (pix_data_i),
    .in_ready_o  (fifo_ready),
    .out_valid_o (pix_avail),
    .out_data_o  (pix),
    .out_ready_i (tick),
    .level_o     (fifo_lvl)
  );

  wire take = tick & pix_avail;  // Pixel consumed this cycle

  // ****************************************
  // Line sync width and pixel phase
  // ****************************************
  logic       ls_prev_r;
  logic [7:0] hs_cnt_r;
  logic [7:0] hs_cnt_nxt;
  logic       hs_act_nxt;

  // Pulse opens on input line sync, counts pixels
  always_comb
  begin
    hs_cnt_nxt = hs_cnt_r;
    hs_act_nxt = hs_act_r;
    if (pix.line_sync && !ls_prev_r && hsw_r != 8'h00)
    begin
      hs_act_nxt = 1'b1;
      hs_cnt_nxt = hsw_r - 8'h01;
    end
    else if (hs_cnt_r != 8'h00)
      hs_cnt_nxt = hs_cnt_r - 8'h01;
    else
      hs_act_nxt = 1'b0;
  end

  wire trail  = hs_act_r & ~hs_act_nxt;  // Trailing edge of line sync
  wire cur_ph = trail ? 1'b0 : phase_r;  // 0 for the first pixel after it
  wire sec    = cur_ph ^ fmt_r.swap;     // Pixel lands on secondary set

  // ****************************************
  // Bus formatting
  // ****************************************
  dpf_pkg::dpf_bus_t pri_r;
  dpf_pkg::dpf_bus_t sec_r;
  dpf_pkg::dpf_bus_t stash_r;
  dpf_pkg::dpf_bus_t pri_nxt;
  dpf_pkg::dpf_bus_t sec_nxt;
  dpf_pkg::dpf_bus_t pix_bus;
  logic              dclk_r;
  logic              dclk_nxt;

  assign pix_bus = '{red: pix.red, green: pix.green, blue: pix.blue};

  // Next values of both bus sets
  always_comb
  begin
    pri_nxt = pri_r;
    sec_nxt = sec_r;
    if (!fmt_r.wide)
    begin
      sec_nxt = dpf_pkg::BUS_ZERO;
      pri_nxt = pix_bus;
      if (fmt_r.yuv422)
      begin
        pri_nxt.red  = cur_ph ? pix.red : pix.blue;
        pri_nxt.blue = 8'h00;
      end
    end
    else if (fmt_r.interleave)
    begin
      if (sec)
        sec_nxt = pix_bus;
      else
        pri_nxt = pix_bus;
    end
    else if (cur_ph)
    begin
      pri_nxt = fmt_r.swap ? pix_bus : stash_r;
      sec_nxt = fmt_r.swap ? stash_r : pix_bus;
    end
  end

  // Output clock: active edge coincides with the data update
  always_comb
  begin
    dclk_nxt = dclk_r;
    if (!fmt_r.wide)
      dclk_nxt = fmt_r.clk_pol ^ ~pclk_s2_r;
    else if (take && fmt_r.interleave)
      dclk_nxt = fmt_r.clk_pol ^ sec;
    else if (take)
      dclk_nxt = fmt_r.clk_pol ^ ~cur_ph;
  end

  // Datapath state
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pri_r     <= dpf_pkg::BUS_ZERO;
      sec_r     <= dpf_pkg::BUS_ZERO;
      stash_r   <= dpf_pkg::BUS_ZERO;
      ls_prev_r <= 1'b0;
      hs_cnt_r  <= 8'h00;
      hs_act_r  <= 1'b0;
      phase_r   <= 1'b0;
    end
    else if (take)
    begin
      pri_r     <= pri_nxt;
      sec_r     <= sec_nxt;
      stash_r   <= pix_bus;
      ls_prev_r <= pix.line_sync;
      hs_cnt_r  <= hs_cnt_nxt;
      hs_act_r  <= hs_act_nxt;
      phase_r   <= ~cur_ph;
    end
  end

  // Clock and sync outputs
  logic ls_out_r;
  logic fs_out_r;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dclk_r   <= 1'b0;
      ls_out_r <= 1'b0;
      fs_out_r <= 1'b0;
    end
    else
    begin
      dclk_r <= dclk_nxt;
      if (take)
      begin
        ls_out_r <= hs_act_nxt ^ fmt_r.line_pol;
        fs_out_r <= pix.frame_sync ^ fmt_r.frame_pol;
      end
    end
  end

  // ****************************************
  // Lane enables
  // ****************************************
  logic [5:0] lane_oe_n_r;
  logic       dclk_oe_n_r;

  // Disable bits act alone, nothing else gates them
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      lane_oe_n_r <= 6'h00;
      dclk_oe_n_r <= 1'b0;
    end
    else
    begin
      lane_oe_n_r <= dis_r[dpf_pkg::DIS_LANES-1:0];
      dclk_oe_n_r <= dis_r[dpf_pkg::DIS_CLK_A] | dis_r[dpf_pkg::DIS_CLK_B];
    end
  end

  // ****************************************
  // Output assignments
  // ****************************************
  assign wb_dat_o                 = rdat_r;
  assign wb_ack_o                 = ack_r;
  assign pix_ready_o              = fifo_ready;
  assign red_primary_bus_o        = pri_r.red;
  assign green_primary_bus_o      = pri_r.green;
  assign blue_primary_bus_o       = pri_r.blue;
  assign red_secondary_bus_o      = sec_r.red;
  assign green_secondary_bus_o    = sec_r.green;
  assign blue_secondary_bus_o     = sec_r.blue;
  assign lane_oe_n_o              = lane_oe_n_r;
  assign output_data_clock_o      = dclk_r;
  assign output_data_clock_oe_n_o = dclk_oe_n_r;
  assign line_sync_out_o          = ls_out_r;
  assign frame_sync_out_o         = fs_out_r;

endmodule

`default_nettype wire

//--- verif/dpf_asserts.sv
// Port checks of the pixel output formatter
`timescale 1ns/10ps
`default_nettype none

module dpf_asserts (
  // Clock, reset and register bus
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [9:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  // Output side
  input wire logic [7:0]  red_primary_bus_o,
  input wire logic [7:0]  blue_primary_bus_o,
  input wire logic [7:0]  red_secondary_bus_o,
  input wire logic [5:0]  lane_oe_n_o,
  input wire logic        output_data_clock_o,
  input wire logic        output_data_clock_oe_n_o,
  input wire logic        line_sync_out_o
);
  dpf_pkg::dpf_fmt_t fmt_r;
  logic [7:0]        hsw_r, dis_r, cnt_r;
  logic              clk_q_r, wr, upd;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Taken writes and narrow active data edges
  assign wr  = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
  assign upd = ~fmt_r.wide & (output_data_clock_o != clk_q_r)
             & (output_data_clock_o == fmt_r.clk_pol);

  // Shadow copies of the registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      fmt_r <= dpf_pkg::dpf_fmt_t'(dpf_pkg::RST_FMT);
      hsw_r <= dpf_pkg::RST_HSW;
      dis_r <= dpf_pkg::RST_DIS;
    end
    else if (wr)
    begin
      if (wb_adr_i == dpf_pkg::ADR_FMT) fmt_r <= dpf_pkg::dpf_fmt_t'(wb_dat_i[7:0]);
      if (wb_adr_i == dpf_pkg::ADR_HSW) hsw_r <= wb_dat_i[7:0];
      if (wb_adr_i == dpf_pkg::ADR_DIS) dis_r <= wb_dat_i[7:0];
    end
  end

  // Active clock edges counted during the line pulse
  always_ff @(posedge clk_i)
  begin
    clk_q_r <= output_data_clock_o;
    cnt_r   <= line_sync_out_o ? cnt_r + 8'(upd) : 8'h00;
  end

  chk_ack_one_cycle:
    assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_ack_after_req:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  chk_lane_oe_bits:
    assert property (wb_ack_o && wb_we_i |-> ##[0:1] lane_oe_n_o == dis_r[5:0])
    else $error("lane enables differ from disable bits");
  chk_clk_oe_bits:
    assert property (wb_ack_o |-> ##[0:1] output_data_clock_oe_n_o == (|dis_r[7:6]))
    else $error("data clock enable differs from disable bits");
  chk_sec_low_narrow:
    assert property (upd |-> red_secondary_bus_o == 8'h00)
    else $error("secondary bus not low in narrow mode");
  chk_blue_low_422:
    assert property (upd && fmt_r.yuv422 && $changed(red_primary_bus_o)
                     |-> blue_primary_bus_o == 8'h00)
    else $error("blue bus not low in 4:2:2 mode");
  chk_data_on_edge:
    assert property (!fmt_r.wide && $changed(red_primary_bus_o) |-> upd)
    else $error("data changed off the selected clock edge");
  chk_sync_width:
    assert property (!fmt_r.wide && !fmt_r.line_pol && $fell(line_sync_out_o)
                     |-> cnt_r == hsw_r)
    else $error("line sync width differs from setting");
  chk_interleave_edge:
    assert property (fmt_r.wide && fmt_r.interleave && $changed(red_secondary_bus_o)
                     |-> output_data_clock_o != fmt_r.clk_pol)
    else $error("secondary data not on the opposite edge");
endmodule

`default_nettype wire

//--- verif/dpf_sink.sv
// Downstream receiver model with pull-downs on a byte lane
`timescale 1ns/10ps
`default_nettype none

module dpf_sink (
  // Lane from the formatter
  input  wire logic [7:0] red_i,
  input  wire logic       oe_n_i,
  // Level seen at the receiver
  output logic [7:0]      red_o
);
  // Pull-down wins on a three-stated lane
  assign red_o = oe_n_i ? 8'h00 : red_i;
endmodule

`default_nettype wire

//--- verif/dpf_formatter_bench.sv
// Self-checking bench of the pixel output formatter
`timescale 1ns/10ps
`default_nettype none

module dpf_formatter_bench;
  logic              clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, pix_valid_i;
  logic              pix_ready_o, pixel_clock_i, output_data_clock_o, line_sync_out_o;
  logic              output_data_clock_oe_n_o, frame_sync_out_o;
  logic [9:0]        wb_adr_i;
  logic [3:0]        wb_sel_i;
  logic [31:0]       wb_dat_i, wb_dat_o, rd, lf;
  logic [7:0]        red_primary_bus_o, green_primary_bus_o, blue_primary_bus_o, red_seen;
  logic [7:0]        red_secondary_bus_o, green_secondary_bus_o, blue_secondary_bus_o;
  logic [5:0]        lane_oe_n_o;
  logic [23:0]       a, b;
  dpf_pkg::dpf_pix_t pix_data_i;
  int                fails, comparisons;
  wire logic [47:0]  buses = {red_primary_bus_o, green_primary_bus_o, blue_primary_bus_o,
                              red_secondary_bus_o, green_secondary_bus_o, blue_secondary_bus_o};

  dpf_formatter i_dpf_formatter (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .pix_valid_i, .pix_data_i, .pix_ready_o,
    .pixel_clock_i, .red_primary_bus_o, .green_primary_bus_o, .blue_primary_bus_o,
    .red_secondary_bus_o, .green_secondary_bus_o, .blue_secondary_bus_o, .lane_oe_n_o,
    .output_data_clock_o, .output_data_clock_oe_n_o, .line_sync_out_o, .frame_sync_out_o);
  dpf_sink i_dpf_sink (.red_i(red_primary_bus_o), .oe_n_i(lane_oe_n_o[0]), .red_o(red_seen));

  // System clock and unrelated pixel clock
  initial
  begin
    clk_i = 0;
    forever #5 clk_i = ~clk_i;
  end
  initial
  begin
    pixel_clock_i = 0;
    #3;
    forever #62.5 pixel_clock_i = ~pixel_clock_i;
  end

  // Random source and wide pair placement
  function automatic logic [31:0] step(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [47:0] pair(input logic [23:0] f, input logic [23:0] s,
                                       input logic sw);
    return sw ? {s, f} : {f, s};
  endfunction

  task automatic end_of_test;
    if (fails == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic cmp(input logic [47:0] g, input logic [47:0] e);
    comparisons++;
    if (g !== e)
    begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Classic single Wishbone cycle
  task automatic wb(input logic w, input logic [9:0] ad, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i  <= w;
    wb_sel_i <= 4'hf;
    wb_adr_i <= ad;
    wb_dat_i <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    if (n >= 50) fails++;
    @(posedge clk_i);
  endtask

  task automatic rd_chk(input logic [9:0] ad, input logic [7:0] e);
    wb(0, ad, 0, rd);
    cmp(48'(rd), 48'(e));
  endtask

  // Offer one pixel, valid stays up for the next
  task automatic push(input logic [1:0] sy, input logic [23:0] v);
    int n;
    n = 0;
    pix_valid_i <= 1;
    pix_data_i  <= {sy, v};
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (pix_ready_o !== 1'b1 && n < 500);
    if (n >= 500) fails++;
  endtask

  task automatic expect_bus(input logic [47:0] e, input logic [47:0] m);
    int n;
    n = 0;
    while ((buses & m) !== e && n < 400)
    begin
      @(posedge clk_i);
      n++;
    end
    cmp(buses & m, e);
  endtask

  // Main sequence
  initial
  begin
    rst_i = 1; wb_cyc_i = 0; wb_stb_i = 0; wb_we_i = 0; wb_adr_i = 0; wb_sel_i = 4'hf;
    wb_dat_i = 0; pix_valid_i = 0; pix_data_i = '0; fails = 0; comparisons = 0;
    lf = 32'h30ca;
    repeat (5) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    rd_chk(dpf_pkg::ADR_FMT, dpf_pkg::RST_FMT);
    rd_chk(dpf_pkg::ADR_HSW, dpf_pkg::RST_HSW);
    rd_chk(dpf_pkg::ADR_DIS, dpf_pkg::RST_DIS);
    wb(1, 10'h3f0, 32'hff, rd);
    rd_chk(10'h3f0, 8'h00);
    lf = step(lf);
    push(2'b00, lf[23:0]);
    pix_valid_i <= 0;
    expect_bus({lf[23:0], 24'h0}, '1);
    lf = step(lf);
    wb(1, dpf_pkg::ADR_HSW, 32'(lf[2:0]) + 1, rd);
    push(2'b01, lf[23:0]);
    repeat (10)
    begin
      lf = step(lf);
      push(2'b00, lf[23:0]);
    end
    pix_valid_i <= 0;
    expect_bus({lf[23:0], 24'h0}, '1);
    wb(1, dpf_pkg::ADR_FMT, 32'h10, rd);
    lf = step(lf);
    push(2'b00, lf[23:0]);
    pix_valid_i <= 0;
    expect_bus({8'h0, lf[15:8], 8'h0, 24'h0}, 48'h00ffff_ffffff);
    wb(1, dpf_pkg::ADR_FMT, 32'he0, rd);
    lf = step(lf);
    push(2'b00, lf[23:0]);
    pix_valid_i <= 0;
    expect_bus({lf[23:0], 24'h0}, '1);
    cmp(48'({frame_sync_out_o, line_sync_out_o}), 48'h3);
    wb(1, dpf_pkg::ADR_HSW, 32'h2, rd);
    for (int k = 0; k < 2; k++)
    begin
      wb(1, dpf_pkg::ADR_FMT, 32'he1 | 32'(k * 6), rd);
      lf = step(lf);
      a = lf[23:0];
      lf = step(lf);
      b = lf[23:0];
      push(2'b01, b);
      push(2'b00, b);
      push(2'b00, a);
      push(2'b00, b);
      pix_valid_i <= 0;
      expect_bus(pair(a, b, k[0]), '1);
    end
    lf = step(lf);
    wb(1, dpf_pkg::ADR_DIS, lf, rd);
    rd_chk(dpf_pkg::ADR_DIS, lf[7:0]);
    cmp(48'({output_data_clock_oe_n_o, lane_oe_n_o}), 48'({|lf[7:6], lf[5:0]}));
    cmp(48'(red_seen), 48'(lf[0] ? 8'h00 : b[23:16]));
    end_of_test;
  end

  // Watchdog
  initial
  begin
    #300000;
    fails++;
    end_of_test;
  end
endmodule

bind dpf_formatter dpf_asserts i_dpf_asserts (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .red_primary_bus_o, .blue_primary_bus_o,
  .red_secondary_bus_o, .lane_oe_n_o, .output_data_clock_o, .output_data_clock_oe_n_o,
  .line_sync_out_o);

`default_nettype wire
